//--- i2c_master_model.sv
// master transmitter model on the open-drain scl and sda wires
`timescale 1ns/1ps
module i2c_master_model (
  input wire logic scl,
  input wire logic sda,
  output logic scl_low,
  output logic sda_low
);
  // both lines released, pull-ups idle them high
  initial begin
    scl_low = 1'h0;
    sda_low = 1'h0;
  end
  // one high phase, waiting while the slave stretches scl
  task automatic hi(output logic s);
    scl_low = 1'h0;
    wait (scl === 1'h1);
    #31.25;
    s = sda;
    #31.25;
    scl_low = 1'h1;
  endtask
  // start: sda falls while scl is high
  task automatic start_c;
    sda_low = 1'h1;
    #62.5;
    scl_low = 1'h1;
  endtask
  // msb first, sda changed only while scl is low
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      #31.25;
      sda_low = !b[i];
      #31.25;
      hi(s);
    end
    #31.25;
    sda_low = 1'h0;
    #31.25;
    hi(ack);
  endtask
  // stop: sda rises while scl is high
  task automatic stop_c;
    #31.25;
    sda_low = 1'h1;
    #31.25;
    scl_low = 1'h0;
    wait (scl === 1'h1);
    #62.5;
    sda_low = 1'h0;
    #62.5;
  endtask
endmodule

//--- two_wire_slave_receiver.sv
// two-wire slave receiver with apb register access
//
// What this block does
// - answer only own seven-bit address, or general call when enabled
// - address lsb enables general call response
// - write bit gives receive, read bit transmit for own address only (ignored after general call)
// - address with write sets flag and status
// - lost arbitration then addressed enters receive
// - cleared acknowledge enable gives nack next byte
// - no address acknowledge while enable is zero
// - address match with write in deep sleep requests wake
// - scl held low until flag cleared
// - data register not loaded from the bus while asleep, apb writes still update it
// - writing one clears flag, transfer continues
// - prescaler bits of status read zero
// - own address acknowledged reports 0x60
// - lost arbitration reports 0x68 or 0x78
// - general call acknowledged reports 0x70
// - acknowledged data byte reports 0x80, 0x90 after general call
// - nack byte reports 0x88 (0x98 after general call), not addressed
// - start request issues start when bus free
`timescale 1ns/1ps
module two_wire_slave_receiver (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE,
  input wire logic SCL_I,
  output logic SCL_O,
  output logic SCL_OE,
  input wire logic SLEEP,
  input wire logic ARB_LOST,
  output logic WAKE_REQ,
  output logic START_GO,
  output logic SLAVE_TX_GO
);

  // ***********************************
  // state record
  // ***********************************
  typedef struct packed {
    logic sda_s1;
    logic sda_s2;
    logic sda_s3;
    logic scl_s1;
    logic scl_s2;
    logic scl_s3;
    two_wire_slave_receiver_pkg::seq_e seq;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [7:0] own_addr;
    logic ack_en;
    logic start_req;
    logic stop_req;
    logic wcol;
    logic en;
    logic ie;
    logic irq;
    logic [7:0] status;
    logic [7:0] data;
    logic addressed;
    logic gen_call;
    logic addr_phase;
    logic ack_bit;
    logic arb_pend;
    logic busy;
    logic sda_drv;
    logic wake;
    logic start_go;
    logic tx_go;
    logic [31:0] prdata;
    logic pslverr;
  } state_s;

  state_s q;
  state_s d;

  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic wr_acc;
  logic rd_setup;
  logic mapped;
  logic match_own;
  logic match_gc;
  logic [11:0] a;

  // flag set seen in this cycle, so a clear then loses
  logic irq_set;

  // ***********************************
  // bus events from synchronised pins
  // ***********************************
  assign scl_rise = q.scl_s2 & ~q.scl_s3;
  assign scl_fall = ~q.scl_s2 & q.scl_s3;
  assign start_cond = q.scl_s2 & q.scl_s3 & ~q.sda_s2 & q.sda_s3;
  assign stop_cond = q.scl_s2 & q.scl_s3 & q.sda_s2 & ~q.sda_s3;

  // apb decode
  assign a = PADDR;
  assign wr_acc = PSEL & PENABLE & PWRITE;
  assign rd_setup = PSEL & ~PENABLE;
  assign mapped = (a == two_wire_slave_receiver_pkg::OWN_SLAVE_ADDRESS_OFS) ||
                  (a == two_wire_slave_receiver_pkg::SERIAL_CONTROL_OFS) ||
                  (a == two_wire_slave_receiver_pkg::SERIAL_STATUS_OFS) ||
                  (a == two_wire_slave_receiver_pkg::SERIAL_DATA_REGISTER_OFS);

  // address comparison on the received byte
  assign match_own = (q.shift[7:1] == q.own_addr[7:1]);
  assign match_gc = (q.shift[7:1] == two_wire_slave_receiver_pkg::GENERAL_CALL_ADDRESS) & q.own_addr[0];

  // ***********************************
  // next state
  // ***********************************
  always_comb begin
    d = q;
    d.start_go = 1'b0;
    d.tx_go = 1'b0;
    // no flag set event unless one is found below
    irq_set = 1'b0;

    // two-flop synchronisers, third stage for edges
    d.sda_s1 = SDA_I;
    d.sda_s2 = q.sda_s1;
    d.sda_s3 = q.sda_s2;
    d.scl_s1 = SCL_I;
    d.scl_s2 = q.scl_s1;
    d.scl_s3 = q.scl_s2;

    // loss of arbitration noted for the next address
    if (ARB_LOST) begin
      d.arb_pend = 1'b1;
    end

    // wake request drops once the part runs again
    if (!SLEEP) begin
      d.wake = 1'b0;
    end

    // bus busy between start and stop
    if (start_cond) begin
      d.busy = 1'b1;
    end
    if (stop_cond) begin
      d.busy = 1'b0;
    end

    // ***********************************
    // bus sequencer
    // ***********************************
    if (!q.en) begin
      d.seq = two_wire_slave_receiver_pkg::S_IDLE;
      d.sda_drv = 1'b0;
      d.addressed = 1'b0;
    end else if (stop_cond || start_cond) begin
      // stop or repeated start while addressed
      if (q.addressed) begin
        d.status = two_wire_slave_receiver_pkg::ST_STOP_OR_RESTART;
        d.irq = 1'b1;
        irq_set = 1'b1;
      end
      d.addressed = 1'b0;
      d.sda_drv = 1'b0;
      d.bit_cnt = 4'h0;
      d.seq = start_cond ? two_wire_slave_receiver_pkg::S_ADDR : two_wire_slave_receiver_pkg::S_IDLE;
    end else begin
      case (q.seq)
        two_wire_slave_receiver_pkg::S_IDLE: begin
          d.bit_cnt = 4'h0;
        end
        two_wire_slave_receiver_pkg::S_ADDR, two_wire_slave_receiver_pkg::S_DATA: begin
          if (scl_rise && q.bit_cnt != two_wire_slave_receiver_pkg::BITS_PER_BYTE) begin
            d.shift = {q.shift[6:0], q.sda_s2};
            d.bit_cnt = q.bit_cnt + 4'h1;
          end
          if (scl_fall && q.bit_cnt == two_wire_slave_receiver_pkg::BITS_PER_BYTE) begin
            if (q.seq == two_wire_slave_receiver_pkg::S_ADDR) begin
              // ack enable gates any address recognition
              if (q.ack_en && (match_own || match_gc)) begin
                if (!q.shift[0]) begin
                  // write direction: slave receive
                  d.seq = two_wire_slave_receiver_pkg::S_ACK;
                  d.sda_drv = 1'b1;
                  d.ack_bit = 1'b1;
                  d.addr_phase = 1'b1;
                  d.gen_call = ~match_own;
                  d.addressed = 1'b1;
                  if (SLEEP) begin
                    d.wake = 1'b1;
                  end
                end else if (match_own) begin
                  // read direction hands over to transmit logic
                  d.tx_go = 1'b1;
                  // a loss in this very cycle stays pending
                  d.arb_pend = ARB_LOST;
                  d.seq = two_wire_slave_receiver_pkg::S_IDLE;
                end else begin
                  d.seq = two_wire_slave_receiver_pkg::S_IDLE;
                end
              end else begin
                // not for us, keep watching the bus
                d.seq = two_wire_slave_receiver_pkg::S_IDLE;
              end
            end else begin
              // data byte complete, ack follows ack enable
              d.seq = two_wire_slave_receiver_pkg::S_ACK;
              d.ack_bit = q.ack_en;
              d.sda_drv = q.ack_en;
              d.addr_phase = 1'b0;
              if (!SLEEP) begin
                d.data = q.shift;
              end
            end
          end
        end
        two_wire_slave_receiver_pkg::S_ACK: begin
          // end of ninth clock: release sda, post status
          if (scl_fall) begin
            d.sda_drv = 1'b0;
            d.irq = 1'b1;
            irq_set = 1'b1;
            d.seq = two_wire_slave_receiver_pkg::S_HOLD;
            if (q.addr_phase) begin
              // a loss in this very cycle stays pending
              d.arb_pend = ARB_LOST;
              if (q.gen_call) begin
                d.status = q.arb_pend ? two_wire_slave_receiver_pkg::ST_ARB_GEN_CALL_ACK :
                                        two_wire_slave_receiver_pkg::ST_GEN_CALL_ACK;
              end else begin
                d.status = q.arb_pend ? two_wire_slave_receiver_pkg::ST_ARB_OWN_ADDR_ACK :
                                        two_wire_slave_receiver_pkg::ST_OWN_ADDR_ACK;
              end
            end else if (q.ack_bit) begin
              d.status = q.gen_call ? two_wire_slave_receiver_pkg::ST_GC_DATA_ACK :
                                      two_wire_slave_receiver_pkg::ST_OWN_DATA_ACK;
            end else begin
              // nack returned: not addressed any more
              d.status = q.gen_call ? two_wire_slave_receiver_pkg::ST_GC_DATA_NACK :
                                      two_wire_slave_receiver_pkg::ST_OWN_DATA_NACK;
              d.addressed = 1'b0;
            end
          end
        end
        two_wire_slave_receiver_pkg::S_HOLD: begin
          // scl is stretched here until the flag clears
          if (!q.irq) begin
            d.bit_cnt = 4'h0;
            d.seq = q.addressed ? two_wire_slave_receiver_pkg::S_DATA : two_wire_slave_receiver_pkg::S_IDLE;
          end
        end
        default: begin
          d.seq = two_wire_slave_receiver_pkg::S_IDLE;
        end
      endcase
    end

    // start once the bus is free, request then consumed
    if (q.en && q.start_req && !q.busy && !q.irq && q.seq == two_wire_slave_receiver_pkg::S_IDLE) begin
      d.start_go = 1'b1;
      d.start_req = 1'b0;
    end

    // ***********************************
    // apb register writes
    // ***********************************
    if (wr_acc) begin
      case (a)
        two_wire_slave_receiver_pkg::OWN_SLAVE_ADDRESS_OFS: begin
          d.own_addr = PWDATA[7:0];
        end
        two_wire_slave_receiver_pkg::SERIAL_CONTROL_OFS: begin
          d.ack_en = PWDATA[two_wire_slave_receiver_pkg::ACK_ENABLE_BIT];
          d.start_req = PWDATA[two_wire_slave_receiver_pkg::START_REQUEST_BIT];
          d.stop_req = PWDATA[two_wire_slave_receiver_pkg::STOP_REQUEST_BIT];
          d.en = PWDATA[two_wire_slave_receiver_pkg::INTERFACE_ENABLE_BIT];
          d.ie = PWDATA[two_wire_slave_receiver_pkg::IRQ_ENABLE_BIT];
          // write one clears the flag, a same-cycle set wins
          if (PWDATA[two_wire_slave_receiver_pkg::IRQ_FLAG_BIT] && !irq_set) begin
            d.irq = 1'b0;
            d.status = two_wire_slave_receiver_pkg::ST_NO_INFO;
          end
        end
        two_wire_slave_receiver_pkg::SERIAL_DATA_REGISTER_OFS: begin
          // data writes only allowed while the flag is up
          if (q.irq) begin
            d.data = PWDATA[7:0];
            d.wcol = 1'b0;
          end else begin
            d.wcol = 1'b1;
          end
        end
        default: begin
          d.wcol = d.wcol;
        end
      endcase
    end

    // ***********************************
    // apb read data captured at setup
    // ***********************************
    if (rd_setup) begin
      d.pslverr = ~mapped;
      d.prdata = 32'h0000_0000;
      case (a)
        two_wire_slave_receiver_pkg::OWN_SLAVE_ADDRESS_OFS: begin
          d.prdata[7:0] = q.own_addr;
        end
        two_wire_slave_receiver_pkg::SERIAL_CONTROL_OFS: begin
          d.prdata[7:0] = {q.irq, q.ack_en, q.start_req, q.stop_req, q.wcol, q.en, 1'b0, q.ie};
        end
        two_wire_slave_receiver_pkg::SERIAL_STATUS_OFS: begin
          d.prdata[7:0] = {q.status[7:3], 3'b000};
        end
        two_wire_slave_receiver_pkg::SERIAL_DATA_REGISTER_OFS: begin
          d.prdata[7:0] = q.data;
        end
        default: begin
          d.prdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // ***********************************
  // state register
  // ***********************************
  always_ff @(posedge CLK) begin
    if (RESET) begin
      q <= '0;
      q.sda_s1 <= 1'b1;
      q.sda_s2 <= 1'b1;
      q.sda_s3 <= 1'b1;
      q.scl_s1 <= 1'b1;
      q.scl_s2 <= 1'b1;
      q.scl_s3 <= 1'b1;
      q.seq <= two_wire_slave_receiver_pkg::S_IDLE;
      q.own_addr <= two_wire_slave_receiver_pkg::OWN_SLAVE_ADDRESS_RST;
      q.data <= two_wire_slave_receiver_pkg::SERIAL_DATA_RST;
      q.status <= two_wire_slave_receiver_pkg::ST_NO_INFO;
    end else begin
      q <= d;
    end
  end

  // ***********************************
  // outputs
  // ***********************************
  assign PRDATA = q.prdata;
  assign PREADY = 1'b1; // zero wait states
  assign PSLVERR = q.pslverr & PSEL & PENABLE;
  assign SDA_O = 1'b0; // open drain, only pulls low
  assign SDA_OE = q.sda_drv;
  assign SCL_O = 1'b0;
  assign SCL_OE = (q.seq == two_wire_slave_receiver_pkg::S_HOLD) & q.irq;
  assign WAKE_REQ = q.wake;
  assign START_GO = q.start_go;
  assign SLAVE_TX_GO = q.tx_go;

endmodule

//--- two_wire_slave_receiver_bench.sv
// self-checking bench for the two-wire slave receiver
`timescale 1ns/1ps
module two_wire_slave_receiver_bench;
  localparam logic [11:0] A_OWN = two_wire_slave_receiver_pkg::OWN_SLAVE_ADDRESS_OFS;
  localparam logic [11:0] A_CTL = two_wire_slave_receiver_pkg::SERIAL_CONTROL_OFS;
  localparam logic [11:0] A_ST = two_wire_slave_receiver_pkg::SERIAL_STATUS_OFS;
  localparam logic [11:0] A_DAT = two_wire_slave_receiver_pkg::SERIAL_DATA_REGISTER_OFS;
  logic CLK = 1'h0, RESET = 1'h1, PSEL = 1'h0, PENABLE = 1'h0, PWRITE = 1'h0, SLEEP = 1'h0, ARB_LOST = 1'h0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h00000000, PRDATA, r;
  logic PREADY, PSLVERR, SDA_O, SDA_OE, SCL_O, SCL_OE, WAKE_REQ, START_GO, SLAVE_TX_GO, e;
  logic go_seen = 1'h0, tx_seen = 1'h0;
  logic [6:0] oa;
  logic [7:0] d;
  wire logic m_scl, m_sda;
  int fails = 0, checked = 0, seed = 14518;
  // open-drain wires with pull-ups
  wire logic scl = !((SCL_OE && !SCL_O) || m_scl);
  wire logic sda = !((SDA_OE && !SDA_O) || m_sda);
  two_wire_slave_receiver i_dut (.CLK, .RESET, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
    .PSLVERR, .SDA_I(sda), .SDA_O, .SDA_OE, .SCL_I(scl), .SCL_O, .SCL_OE, .SLEEP, .ARB_LOST, .WAKE_REQ,
    .START_GO, .SLAVE_TX_GO);
  i2c_master_model i_m (.scl, .sda, .scl_low(m_scl), .sda_low(m_sda));
  // system clock
  always #5 CLK = !CLK;
  // sticky record of the one-cycle pulses
  always @(posedge CLK) begin
    if (START_GO === 1'h1)
      go_seen <= 1'h1;
    if (SLAVE_TX_GO === 1'h1)
      tx_seen <= 1'h1;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
      begin
      fails++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // apb transfer: setup, then access until pready
  task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] wd);
    @(posedge CLK);
    PSEL <= 1'h1;
    PENABLE <= 1'h0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= {24'h000000, wd};
    @(posedge CLK);
    PENABLE <= 1'h1;
    do begin
      @(posedge CLK);
    end while (PREADY !== 1'h1);
    chk(PREADY, 32'h1);
    r = PRDATA;
    e = PSLVERR;
    PSEL <= 1'h0;
    PENABLE <= 1'h0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] x);
    apb(a, 1'h0, 8'h00);
    chk(r, {24'h000000, x});
  endtask
  // one byte on the bus, then the software reaction
  task automatic bx(input logic [7:0] b, input logic ack, input logic [7:0] st, input logic [7:0] ctl);
    logic s;
    i_m.send_byte(b, s);
    chk(s, !ack);
    // flag and stretch show a few cycles after the ninth fall
    repeat (5) @(posedge CLK);
    chk(SCL_OE, {31'h0, st != 8'h00});
    if (st == 8'h00) begin
      rd(A_ST, 8'hF8);
    end else begin
      rd(A_ST, st);
      if (st[7])
        rd(A_DAT, b);
      apb(A_CTL, 1'h1, 8'h80 | ctl);
    end
  endtask
  task automatic sp(input logic adr);
    i_m.stop_c;
    if (adr) begin
      rd(A_ST, 8'hA0);
      apb(A_CTL, 1'h1, 8'hC4);
    end
  endtask
  // watchdog
  initial begin
    #400000;
    fails++;
    test_done;
  end
  // main sequence
  initial begin
    repeat (4) @(posedge CLK);
    RESET <= 1'h0;
    rd(A_OWN, 8'h00);
    rd(A_CTL, 8'h00);
    rd(A_ST, 8'hF8);
    rd(A_DAT, 8'hFF);
    rd(12'h010, 8'h00);
    chk(e, 1'h1);
    $display("test registers done");
    d = $random(seed);
    oa = {1'h1, d[5:0]};
    apb(A_OWN, 1'h1, {oa, 1'h1});
    apb(A_CTL, 1'h1, 8'h44);
    i_m.start_c;
    bx({oa, 1'h0}, 1'h1, 8'h60, 8'h44);
    for (int k = 0; k < 3; k++) begin
      d = $random(seed);
      bx(d, 1'h1, 8'h80, k == 2 ? 8'h04 : 8'h44);
    end
    d = $random(seed);
    bx(d, 1'h0, 8'h88, 8'hE4);
    sp(1'h0);
    for (int n = 0; n < 50 && !go_seen; n++)
      @(posedge CLK);
    chk(go_seen, 1'h1);
    $display("test nack done");
    for (int k = 0; k < 4; k++) begin
      @(posedge CLK);
      ARB_LOST <= k[0];
      @(posedge CLK);
      ARB_LOST <= 1'h0;
      i_m.start_c;
      bx(k[1] ? 8'h00 : {oa, 1'h0}, 1'h1, 8'h60 + 8'(k * 8), 8'h44);
      d = $random(seed);
      bx(d, 1'h1, k[1] ? 8'h90 : 8'h80, 8'h44);
      sp(1'h1);
    end
    $display("test status codes done");
    apb(A_OWN, 1'h1, {oa, 1'h0});
    i_m.start_c;
    bx(8'h00, 1'h0, 8'h00, 8'h00);
    sp(1'h0);
    i_m.start_c;
    bx({oa ^ 7'h01, 1'h0}, 1'h0, 8'h00, 8'h00);
    sp(1'h0);
    apb(A_CTL, 1'h1, 8'h04);
    i_m.start_c;
    bx({oa, 1'h0}, 1'h0, 8'h00, 8'h00);
    sp(1'h0);
    apb(A_CTL, 1'h1, 8'h44);
    i_m.start_c;
    bx({oa, 1'h1}, 1'h0, 8'h00, 8'h00);
    chk(tx_seen, 1'h1);
    sp(1'h0);
    $display("test refusals done");
    @(posedge CLK);
    SLEEP <= 1'h1;
    i_m.start_c;
    bx({oa, 1'h0}, 1'h1, 8'h60, 8'h44);
    chk(WAKE_REQ, 1'h1);
    @(posedge CLK);
    SLEEP <= 1'h0;
    sp(1'h1);
    $display("test sleep done");
    // second reset in mid-run, registers back to their reset values
    @(posedge CLK);
    RESET <= 1'h1;
    repeat (4) @(posedge CLK);
    RESET <= 1'h0;
    rd(A_CTL, 8'h00);
    rd(A_ST, 8'hF8);
    $display("test reset done");
    test_done;
  end
endmodule

//--- two_wire_slave_receiver_chk.sv
// port-level assertion checker for the two-wire slave receiver
`timescale 1ns/1ps
module two_wire_slave_receiver_chk (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic SDA_I,
  input wire logic SDA_OE,
  input wire logic SCL_I,
  input wire logic SCL_OE,
  input wire logic SLEEP,
  input wire logic WAKE_REQ,
  input wire logic START_GO,
  input wire logic SLAVE_TX_GO
);
  // flag-clear write and status read in the access phase
  wire logic clr = PSEL && PENABLE && PWRITE && PADDR == two_wire_slave_receiver_pkg::SERIAL_CONTROL_OFS
    && PWDATA[two_wire_slave_receiver_pkg::IRQ_FLAG_BIT];
  wire logic rd_st = PSEL && PENABLE && !PWRITE && PADDR == two_wire_slave_receiver_pkg::SERIAL_STATUS_OFS;
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  // ack, stretch, status, wake and pulse checks
  ack_rise_a: assert property ($rose(SDA_OE) |-> !SCL_I && !$past(SCL_I, 2))
    else $error("ack driven outside scl low");
  ack_hold_a: assert property ($rose(SCL_I) && SDA_OE |-> SDA_OE [*6])
    else $error("ack dropped during ninth clock");
  stretch_low_a: assert property ($rose(SCL_OE) |-> !$past(SCL_I, 2))
    else $error("stretch began outside scl low");
  stretch_hold_a: assert property (SCL_OE && !clr |=> SCL_OE)
    else $error("stretch released without flag clear");
  stretch_free_a: assert property (SCL_OE && clr |=> !SCL_OE)
    else $error("stretch kept after flag clear");
  status_low_a: assert property (rd_st |-> PRDATA[2:0] == 3'h0)
    else $error("status low bits not zero");
  wake_sleep_a: assert property ($rose(WAKE_REQ) |-> $past(SLEEP))
    else $error("wake request while awake");
  wake_drop_a: assert property (!SLEEP |=> !WAKE_REQ)
    else $error("wake request kept after sleep");
  txgo_pulse_a: assert property (SLAVE_TX_GO |-> !SDA_OE ##1 !SLAVE_TX_GO)
    else $error("transmit handover wrong");
  startgo_idle_a: assert property (START_GO |-> SCL_I && SDA_I ##1 !START_GO)
    else $error("start issued on busy bus");
endmodule
bind two_wire_slave_receiver two_wire_slave_receiver_chk i_chk (.CLK, .RESET, .PSEL, .PENABLE, .PWRITE,
  .PADDR, .PWDATA, .PRDATA, .SDA_I, .SDA_OE, .SCL_I, .SCL_OE, .SLEEP, .WAKE_REQ, .START_GO, .SLAVE_TX_GO);

//--- two_wire_slave_receiver_pkg.sv
// constants, register map and state encodings of the two-wire slave receiver
package two_wire_slave_receiver_pkg;

  // ***********************************
  // register byte addresses on apb
  // ***********************************
  localparam logic [11:0] OWN_SLAVE_ADDRESS_OFS = 12'h000;
  localparam logic [11:0] SERIAL_CONTROL_OFS = 12'h004;
  localparam logic [11:0] SERIAL_STATUS_OFS = 12'h008;
  localparam logic [11:0] SERIAL_DATA_REGISTER_OFS = 12'h00C;

  // ***********************************
  // serial_control bit positions
  // ***********************************
  localparam int IRQ_FLAG_BIT = 7;
  localparam int ACK_ENABLE_BIT = 6;
  localparam int START_REQUEST_BIT = 5;
  localparam int STOP_REQUEST_BIT = 4;
  localparam int WRITE_COLLISION_BIT = 3;
  localparam int INTERFACE_ENABLE_BIT = 2;
  localparam int IRQ_ENABLE_BIT = 0;

  // ***********************************
  // values after reset
  // ***********************************
  localparam logic [7:0] OWN_SLAVE_ADDRESS_RST = 8'h00;
  localparam logic [7:0] SERIAL_DATA_RST = 8'hFF;

  // ***********************************
  // status codes, prescaler bits zero
  // ***********************************
  localparam logic [7:0] ST_OWN_ADDR_ACK = 8'h60;
  localparam logic [7:0] ST_ARB_OWN_ADDR_ACK = 8'h68;
  localparam logic [7:0] ST_GEN_CALL_ACK = 8'h70;
  localparam logic [7:0] ST_ARB_GEN_CALL_ACK = 8'h78;
  localparam logic [7:0] ST_OWN_DATA_ACK = 8'h80;
  localparam logic [7:0] ST_OWN_DATA_NACK = 8'h88;
  localparam logic [7:0] ST_GC_DATA_ACK = 8'h90;
  localparam logic [7:0] ST_GC_DATA_NACK = 8'h98;
  localparam logic [7:0] ST_STOP_OR_RESTART = 8'hA0;
  localparam logic [7:0] ST_NO_INFO = 8'hF8;

  // ***********************************
  // bus constants
  // ***********************************
  localparam logic [6:0] GENERAL_CALL_ADDRESS = 7'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // bus-side sequencer, gray coded along idle-addr-ack-hold-data
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_ADDR = 3'b001,
    S_ACK  = 3'b011,
    S_HOLD = 3'b010,
    S_DATA = 3'b110
  } seq_e;

endpackage
